/* File: include/cpc_pkg.sv */
// Constants for the configuration port control block.
// Assumes one system clock; all pins are sampled by it.
// Behaviour
// - Clear held low: clear memory, status low
// - On release: finish pass, one more, wait
// - Ignore bits until 4-bit sentinel 0010
// - Length counter counts config_clock rising edges from preamble through load
// - Direction low loads, high reads back
// - Unexpected direction change aborts the transfer
// - Hunt 32-bit sync word before loading words
// - Readback serial bitwise, parallel bytewise
// - Readback in frames, optionally captured states
// - Busy high on edge: byte not taken
// - Data error pulls status line low
package cpc_pkg;

  localparam int            WORD_W      = 32;
  localparam int            BYTE_W      = 8;
  localparam int            CNT_W       = 6;
  localparam int            PREAMBLE_W  = 4;
  localparam logic [3:0]    PREAMBLE    = 4'h2;
  localparam logic [5:0]    STEP_SERIAL = 6'h01;
  localparam logic [5:0]    STEP_PAR    = 6'h08;
  localparam logic [5:0]    CNT_WORD    = 6'h20;
  localparam logic [5:0]    CNT_ZERO    = 6'h00;

  typedef enum logic [3:0] {
    CPC_CLEAR,
    CPC_CLEAR_FINAL,
    CPC_WAIT,
    CPC_PREAMBLE,
    CPC_LENGTH,
    CPC_SYNC,
    CPC_LOAD,
    CPC_DONE,
    CPC_READBACK,
    CPC_ABORT,
    CPC_ERROR
  } cpc_state_type;

endpackage

/* File: hw/cpc_config_port_control.sv */
// Configuration port front end: clear sequence, header, sync, load, readback.
// Assumes pins arrive asynchronous to i_clock; config_clock is sampled.
`timescale 1ns/1ns
module cpc_config_port_control #(
  parameter int          MEM_WORDS   = 64,
  parameter int          FRAME_WORDS = 8,
  parameter int          LEN_W       = 24,
  parameter int          LCNT_W      = 32,
  parameter logic [31:0] SYNC_WORD   = 32'h5A5AC3C3
) (
  input  wire logic              i_clock,
  input  wire logic              i_arst_n,
  input  wire logic              i_config_clock,
  input  wire logic              i_config_clear_n,
  input  wire logic              i_par_mode,
  input  wire logic              i_direction,
  input  wire logic              i_serial_din,
  input  wire logic [7:0]        i_par_data,
  input  wire logic              i_readback_start,
  input  wire logic              i_capture_req,
  input  wire logic [31:0]       i_cell_states,
  output logic                   o_status_out,
  output logic                   o_status_oe,
  output logic                   o_busy,
  output logic                   o_serial_dout,
  output logic [7:0]             o_par_data,
  output logic                   o_par_data_oe,
  output logic [LCNT_W-1:0]      o_bitstream_length_counter,
  output logic                   o_frame_start,
  output logic                   o_abort,
  output logic                   o_done
);

  localparam int ADDR_W = (MEM_WORDS > 1) ? $clog2(MEM_WORDS) : 1;
  localparam int FRM_W  = (FRAME_WORDS > 1) ? $clog2(FRAME_WORDS) : 1;
  localparam logic [ADDR_W-1:0] ADDR_LAST = ADDR_W'(MEM_WORDS - 1);
  localparam logic [FRM_W-1:0]  FRM_LAST  = FRM_W'(FRAME_WORDS - 1);
  localparam int SYNC_N = 14;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [SYNC_N-1:0] sync1_r;
  logic [SYNC_N-1:0] sync2_r;
  logic              config_clock_d_r;
  logic              dir_d_r;

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sync1_r  <= '0;
      sync2_r  <= '0;
      config_clock_d_r <= 1'b0;
      dir_d_r  <= 1'b0;
    end else begin
      sync1_r  <= {i_config_clock, i_config_clear_n, i_par_mode, i_direction,
                   i_serial_din, i_readback_start, i_par_data};
      sync2_r  <= sync1_r;
      config_clock_d_r <= sync2_r[13];
      dir_d_r  <= sync2_r[10];
    end
  end

  logic       config_clock_s;
  logic       clear_n_s;
  logic       par_s;
  logic       dir_s;
  logic       din_s;
  logic       rb_s;
  logic [7:0] byte_s;
  assign config_clock_s    = sync2_r[13];
  assign clear_n_s = sync2_r[12];
  assign par_s     = sync2_r[11];
  assign dir_s     = sync2_r[10];
  assign din_s     = sync2_r[9];
  assign rb_s      = sync2_r[8];
  assign byte_s    = sync2_r[7:0];

  ////////////////////////////////////////////////////////////////////////////
  // Datapath
  cpc_pkg::cpc_state_type state_r;
  logic [ADDR_W-1:0]      addr_r;
  logic [FRM_W-1:0]       frm_r;
  logic [5:0]             bit_cnt_r;
  logic [31:0]            shift_r;
  logic [LEN_W-1:0]       len_field_r;
  logic [31:0]            cap_word_r;
  logic                   cap_valid_r;
  logic                   cap_phase_r;
  logic [31:0]            mem [MEM_WORDS];

  logic        config_clock_rise;
  logic        take;
  logic        dir_change;
  logic        counting;
  logic        accepting;
  logic [5:0]  step;
  logic [5:0]  cnt_nxt;
  logic [31:0] shift_nxt;
  logic [31:0] rd_word;
  logic [31:0] rd_sel;

  assign config_clock_rise  = config_clock_s & ~config_clock_d_r;
  assign take       = config_clock_rise & ~o_busy;
  assign dir_change = dir_s ^ dir_d_r;
  assign step       = par_s ? cpc_pkg::STEP_PAR : cpc_pkg::STEP_SERIAL;
  assign cnt_nxt    = bit_cnt_r + step;
  assign shift_nxt  = par_s ? {shift_r[23:0], byte_s} : {shift_r[30:0], din_s};
  assign rd_word    = cap_phase_r ? cap_word_r : mem[addr_r];
  assign rd_sel     = rd_word << bit_cnt_r;
  assign counting   = state_r inside {cpc_pkg::CPC_PREAMBLE, cpc_pkg::CPC_LENGTH,
                                      cpc_pkg::CPC_SYNC, cpc_pkg::CPC_LOAD};
  assign accepting  = counting || state_r == cpc_pkg::CPC_READBACK;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration memory
  always_ff @(posedge i_clock) begin
    if (state_r inside {cpc_pkg::CPC_CLEAR, cpc_pkg::CPC_CLEAR_FINAL}) begin
      mem[addr_r] <= '0;
    end else if (state_r == cpc_pkg::CPC_LOAD && take && cnt_nxt == cpc_pkg::CNT_WORD) begin
      mem[addr_r] <= shift_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Captured cell states
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cap_word_r  <= '0;
      cap_valid_r <= 1'b0;
    end else if (i_capture_req) begin
      cap_word_r  <= i_cell_states;
      cap_valid_r <= 1'b1;
    end else if (state_r == cpc_pkg::CPC_CLEAR) begin
      cap_valid_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Length counter
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_bitstream_length_counter <= '0;
    end else if (state_r == cpc_pkg::CPC_WAIT) begin
      o_bitstream_length_counter <= '0;
    end else if (counting && config_clock_rise) begin
      o_bitstream_length_counter <= o_bitstream_length_counter + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_r     <= cpc_pkg::CPC_CLEAR;
      addr_r      <= '0;
      frm_r       <= '0;
      bit_cnt_r   <= cpc_pkg::CNT_ZERO;
      shift_r     <= '0;
      len_field_r <= '0;
      cap_phase_r <= 1'b0;
    end else if (!clear_n_s && !(state_r inside {cpc_pkg::CPC_CLEAR})) begin
      state_r <= cpc_pkg::CPC_CLEAR;
      addr_r  <= '0;
    end else begin
      unique case (state_r)
        cpc_pkg::CPC_CLEAR: begin
          addr_r <= addr_r + 1'b1;
          if (addr_r == ADDR_LAST) begin
            addr_r <= '0;
            if (clear_n_s) begin
              state_r <= cpc_pkg::CPC_CLEAR_FINAL;
            end
          end
        end
        cpc_pkg::CPC_CLEAR_FINAL: begin
          addr_r <= addr_r + 1'b1;
          if (addr_r == ADDR_LAST) begin
            addr_r  <= '0;
            state_r <= cpc_pkg::CPC_WAIT;
          end
        end
        cpc_pkg::CPC_WAIT: begin
          bit_cnt_r <= cpc_pkg::CNT_ZERO;
          shift_r   <= '0;
          if (!dir_s) begin
            state_r <= cpc_pkg::CPC_PREAMBLE;
          end
        end
        cpc_pkg::CPC_PREAMBLE, cpc_pkg::CPC_LENGTH, cpc_pkg::CPC_SYNC, cpc_pkg::CPC_LOAD: begin
          if (dir_change) begin
            state_r <= cpc_pkg::CPC_ABORT;
          end else if (take) begin
            shift_r   <= shift_nxt;
            bit_cnt_r <= cnt_nxt;
            if (state_r == cpc_pkg::CPC_PREAMBLE) begin
              if (shift_nxt[cpc_pkg::PREAMBLE_W-1:0] == cpc_pkg::PREAMBLE) begin
                state_r   <= cpc_pkg::CPC_LENGTH;
                bit_cnt_r <= cpc_pkg::CNT_ZERO;
              end
            end else if (state_r == cpc_pkg::CPC_LENGTH) begin
              if (cnt_nxt >= 6'(LEN_W)) begin
                len_field_r <= shift_nxt[LEN_W-1:0];
                state_r     <= cpc_pkg::CPC_SYNC;
              end
            end else if (state_r == cpc_pkg::CPC_SYNC) begin
              if (shift_nxt == SYNC_WORD) begin
                state_r   <= cpc_pkg::CPC_LOAD;
                bit_cnt_r <= cpc_pkg::CNT_ZERO;
                addr_r    <= '0;
              end
            end else if (cnt_nxt == cpc_pkg::CNT_WORD) begin
              bit_cnt_r <= cpc_pkg::CNT_ZERO;
              addr_r    <= addr_r + 1'b1;
              if (addr_r == ADDR_LAST) begin
                state_r <= cpc_pkg::CPC_DONE;
                addr_r  <= '0;
              end
            end else if (LCNT_W'(len_field_r) <= o_bitstream_length_counter) begin
              state_r <= cpc_pkg::CPC_ERROR;
            end
          end
        end
        cpc_pkg::CPC_DONE: begin
          bit_cnt_r   <= cpc_pkg::CNT_ZERO;
          frm_r       <= '0;
          cap_phase_r <= 1'b0;
          if (rb_s && dir_s) begin
            state_r <= cpc_pkg::CPC_READBACK;
            addr_r  <= '0;
          end
        end
        cpc_pkg::CPC_READBACK: begin
          if (dir_change) begin
            state_r <= cpc_pkg::CPC_ABORT;
          end else if (take) begin
            bit_cnt_r <= cnt_nxt;
            if (cnt_nxt == cpc_pkg::CNT_WORD) begin
              bit_cnt_r <= cpc_pkg::CNT_ZERO;
              frm_r     <= (frm_r == FRM_LAST) ? '0 : frm_r + 1'b1;
              if (cap_phase_r) begin
                state_r <= cpc_pkg::CPC_DONE;
              end else if (addr_r == ADDR_LAST) begin
                addr_r <= '0;
                if (cap_valid_r) begin
                  cap_phase_r <= 1'b1;
                end else begin
                  state_r <= cpc_pkg::CPC_DONE;
                end
              end else begin
                addr_r <= addr_r + 1'b1;
              end
            end
          end
        end
        cpc_pkg::CPC_ABORT: begin
          state_r <= cpc_pkg::CPC_WAIT;
          addr_r  <= '0;
        end
        cpc_pkg::CPC_ERROR: begin
          state_r <= cpc_pkg::CPC_ERROR;
        end
        default: begin
          state_r <= cpc_pkg::CPC_CLEAR;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_status_oe   <= 1'b1;
      o_busy        <= 1'b1;
      o_serial_dout <= 1'b0;
      o_par_data    <= '0;
      o_par_data_oe <= 1'b0;
      o_frame_start <= 1'b0;
      o_abort       <= 1'b0;
      o_done        <= 1'b0;
    end else begin
      o_status_oe   <= state_r inside {cpc_pkg::CPC_CLEAR, cpc_pkg::CPC_CLEAR_FINAL,
                                       cpc_pkg::CPC_ERROR};
      o_busy        <= par_s & ~accepting;
      o_par_data_oe <= par_s & dir_s & (state_r == cpc_pkg::CPC_READBACK);
      o_abort       <= state_r == cpc_pkg::CPC_ABORT;
      o_done        <= state_r == cpc_pkg::CPC_DONE;
      o_frame_start <= 1'b0;
      if (state_r == cpc_pkg::CPC_READBACK && take) begin
        o_serial_dout <= rd_sel[cpc_pkg::WORD_W-1];
        o_par_data    <= rd_sel[cpc_pkg::WORD_W-1 -: cpc_pkg::BYTE_W];
        o_frame_start <= (bit_cnt_r == cpc_pkg::CNT_ZERO) && (frm_r == '0);
      end
    end
  end

  assign o_status_out = 1'b0;

endmodule

/* File: verification/cpc_config_port_control_asserts.sv */
// Port checker for the configuration port control block.
// Assumes it is bound into cpc_config_port_control with its parameters.
`timescale 1ns/1ns
module cpc_config_port_control_asserts #(
  parameter int MEM_WORDS = 64,
  parameter int LEN_W     = 24,
  parameter int LCNT_W    = 32
) (
  input wire logic              i_clock,
  input wire logic              i_arst_n,
  input wire logic              i_config_clock,
  input wire logic              i_config_clear_n,
  input wire logic              i_par_mode,
  input wire logic              o_status_oe,
  input wire logic              o_busy,
  input wire logic              o_par_data_oe,
  input wire logic [LCNT_W-1:0] o_bitstream_length_counter,
  input wire logic              o_frame_start,
  input wire logic              o_abort,
  input wire logic              o_done
);
  localparam int REL_MAX = 2 * MEM_WORDS + 8;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);
  ////////////////////////////////////////
  property p_clear_hold; !i_config_clear_n [*5] |-> o_status_oe; endproperty
  a_clear_hold: assert property (p_clear_hold) else $error("status free during clear");
  property p_rel_hold; $rose(i_config_clear_n) |=> o_status_oe [*8]; endproperty
  a_rel_hold: assert property (p_rel_hold) else $error("status freed too early");
  property p_rel_bound; $rose(i_config_clear_n) |-> ##[8:REL_MAX] !o_status_oe; endproperty
  a_rel_bound: assert property (p_rel_bound) else $error("status never freed");
  property p_count_step;
    (o_bitstream_length_counter != $past(o_bitstream_length_counter)) && (o_bitstream_length_counter != '0)
      |-> i_config_clock && (o_bitstream_length_counter - $past(o_bitstream_length_counter) == 1);
  endproperty
  a_count_step: assert property (p_count_step) else $error("bad length count step");
  property p_done_count;
    o_done |-> o_bitstream_length_counter >= LCNT_W'(4 + LEN_W + 32 + 32 * MEM_WORDS);
  endproperty
  a_done_count: assert property (p_done_count) else $error("done before full stream");
  property p_serial_busy; !i_par_mode [*6] |-> !o_busy; endproperty
  a_serial_busy: assert property (p_serial_busy) else $error("busy in serial mode");
  property p_serial_bus; !i_par_mode [*4] |-> !o_par_data_oe; endproperty
  a_serial_bus: assert property (p_serial_bus) else $error("byte bus driven in serial mode");
  property p_frame; o_frame_start |-> i_config_clock ##1 !o_frame_start; endproperty
  a_frame: assert property (p_frame) else $error("frame start malformed");
  property p_abort; o_abort |-> !o_done ##1 !o_abort; endproperty
  a_abort: assert property (p_abort) else $error("abort pulse malformed");
endmodule
bind cpc_config_port_control cpc_config_port_control_asserts #(
  .MEM_WORDS(MEM_WORDS), .LEN_W(LEN_W), .LCNT_W(LCNT_W)
) u_asserts (
  .i_clock(i_clock), .i_arst_n(i_arst_n), .i_config_clock(i_config_clock),
  .i_config_clear_n(i_config_clear_n), .i_par_mode(i_par_mode), .o_status_oe(o_status_oe),
  .o_busy(o_busy), .o_par_data_oe(o_par_data_oe), .o_bitstream_length_counter(o_bitstream_length_counter),
  .o_frame_start(o_frame_start), .o_abort(o_abort), .o_done(o_done)
);

/* File: verification/cpc_cfg_master_model.sv */
// Serial configuration master: config clock and data bits.
// Assumes the bench clock; 64 ns config clock, low outside frames.
`timescale 1ns/1ns
module cpc_cfg_master_model (
  input  wire logic i_clock,
  output logic      o_config_clock,
  output logic      o_serial_din
);
  initial begin
    o_config_clock = 1'b0;
    o_serial_din   = 1'b1;
  end
  ////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask
  // n bits MSB first, data held across each rise
  task automatic send(input logic [31:0] v, input int n);
    for (int k = n - 1; k >= 0; k--) begin
      tick(4);
      o_serial_din = v[k];
      tick(4);
      o_config_clock = 1'b1;
      tick(8);
      o_config_clock = 1'b0;
      o_serial_din = ~v[k];
    end
  endtask
endmodule

/* File: verification/cpc_config_port_control_tb.sv */
// Testbench for the configuration port control block.
// Assumes the master model drives config clock and serial data.
`timescale 1ns/1ns
module cpc_config_port_control_tb;
  localparam int          MEMW = 8;
  localparam logic [31:0] SYNC = 32'h5A5AC3C3;
  logic        clock = 1'b0;
  logic        arst_n = 1'b0;
  logic        clr_n = 1'b1;
  logic        dir = 1'b0;
  logic        rb_start = 1'b0;
  logic        rb_phase = 1'b0;
  logic        par = 1'b0;
  logic        capture = 1'b0;
  logic [31:0] cells = 32'h00000000;
  logic        cfg_clk, din, status_oe, busy, dout, frame_start, abort, done;
  logic        status_out, pdata_oe;
  logic [7:0]  pdata;
  logic [31:0] lcnt;
  logic [31:0] words [MEMW];
  logic [7:0]  exp_q [$];
  int          miscompares = 0, cmp_count = 0, cycles = 0, frames = 0, aborts = 0;
  always #2 clock = ~clock;
  cpc_cfg_master_model m (.i_clock(clock), .o_config_clock(cfg_clk), .o_serial_din(din));
  cpc_config_port_control #(.MEM_WORDS(MEMW), .FRAME_WORDS(4), .SYNC_WORD(SYNC)) uut (
    .i_clock(clock), .i_arst_n(arst_n), .i_config_clock(cfg_clk), .i_config_clear_n(clr_n),
    .i_par_mode(par), .i_direction(dir), .i_serial_din(din), .i_par_data(8'h00),
    .i_readback_start(rb_start), .i_capture_req(capture), .i_cell_states(cells),
    .o_status_out(status_out), .o_status_oe(status_oe), .o_busy(busy), .o_serial_dout(dout),
    .o_par_data(pdata), .o_par_data_oe(pdata_oe), .o_bitstream_length_counter(lcnt), .o_frame_start(frame_start),
    .o_abort(abort), .o_done(done));
  ////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    if (miscompares == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wait_idle;
    for (int n = 0; n < 100 && status_oe !== 1'b0; n++) @(posedge clock);
    #1 check(status_oe, 32'h0);
  endtask
  task automatic do_clear;
    @(posedge clock) #1 clr_n = 1'b0;
    repeat (20) @(posedge clock);
    #1 check(status_oe, 32'h1);
    check(status_out, 32'h0);
    clr_n = 1'b1;
    wait_idle();
  endtask
  ////////////////////////////////////////
  always @(negedge cfg_clk) if (rb_phase && exp_q.size() > 0) check(par ? pdata : {7'h00, dout}, exp_q.pop_front());
  always @(posedge clock) begin
    cycles++;
    if (frame_start === 1'b1) frames++;
    if (abort === 1'b1) aborts++;
    if (cycles == 20000) begin
      miscompares++;
      finish_test();
    end
  end
  initial begin
    void'($urandom(24107));
    repeat (4) @(posedge clock);
    #1 arst_n = 1'b1;
    wait_idle();
    m.send(32'h000000F2, 8);
    m.send(32'h00FFFFFF, 24);
    m.send(32'h00000000, 8);
    m.send(SYNC, 32);
    foreach (words[w]) begin
      words[w] = $urandom();
      m.send(words[w], 32);
    end
    check(done, 32'h1);
    check(lcnt, 32'h148);
    check(busy, 32'h0);
    dir = 1'b1;
    rb_start = 1'b1;
    repeat (8) @(posedge clock);
    #1 rb_start = 1'b0;
    check(pdata_oe, 32'h0);
    foreach (words[w]) for (int b = 31; b >= 0; b--) exp_q.push_back(words[w][b]);
    rb_phase = 1'b1;
    repeat (MEMW) m.send($urandom(), 32);
    repeat (2) @(posedge clock);
    #1 rb_phase = 1'b0;
    check(exp_q.size(), 32'h0);
    check(frames, 32'h2);
    check(done, 32'h1);
    par = 1'b1;
    cells = $urandom();
    capture = 1'b1;
    @(posedge clock) #1 capture = 1'b0;
    repeat (3) @(posedge clock);
    #1 check(busy, 32'h1);
    rb_start = 1'b1;
    repeat (8) @(posedge clock);
    #1 rb_start = 1'b0;
    check(pdata_oe, 32'h1);
    check(busy, 32'h0);
    foreach (words[w]) for (int b = 3; b >= 0; b--) exp_q.push_back(words[w][8*b +: 8]);
    for (int b = 3; b >= 0; b--) exp_q.push_back(cells[8*b +: 8]);
    rb_phase = 1'b1;
    m.send($urandom(), 32);
    m.send($urandom(), 4);
    repeat (2) @(posedge clock);
    #1 rb_phase = 1'b0;
    check(exp_q.size(), 32'h0);
    check(frames, 32'h5);
    check(done, 32'h1);
    par = 1'b0;
    dir = 1'b0;
    do_clear();
    m.send(32'h00000002, 8);
    m.send(32'h00000046, 24);
    m.send(SYNC, 32);
    m.send($urandom(), 32);
    check(status_oe, 32'h1);
    check(done, 32'h0);
    do_clear();
    m.send(32'h00000000, 4);
    dir = 1'b1;
    repeat (10) @(posedge clock);
    #1 check(aborts, 32'h1);
    check(lcnt, 32'h0);
    finish_test();
  end
endmodule
